// File: design/io_line_pkg.sv
/*
 * constants for the multiplexed io line controller: sizes, register
 * offsets, field positions and reset values.
 * assumes a 32-bit apb register bus with byte addresses.
 */
package io_line_pkg;
    localparam int          NUM_GROUPS   = 7;
    localparam int          GROUP_LINES  = 32;
    localparam int          NUM_LINES    = 224;
    localparam int          NUM_FUNCS    = 4;
    localparam int          FUNCTION_SELECT_W       = 3;
    localparam int          EVT_W        = 3;
    // register offsets inside one group, groups are 0x40 apart
    localparam logic [5:0]  OFS_MASK     = 6'h00;
    localparam logic [5:0]  OFS_CFG      = 6'h04;
    localparam logic [5:0]  OFS_PINS     = 6'h08;
    localparam logic [5:0]  OFS_SET      = 6'h10;
    localparam logic [5:0]  OFS_CLR      = 6'h14;
    localparam logic [5:0]  OFS_ODS      = 6'h18;
    localparam logic [5:0]  OFS_IEN      = 6'h20;
    localparam logic [5:0]  OFS_IDIS     = 6'h24;
    localparam logic [5:0]  OFS_IMASK    = 6'h28;
    localparam logic [5:0]  OFS_ISTAT    = 6'h2C;
    localparam logic [11:0] ADDR_CLK_EN  = 12'h1C0;
    // fields of the line configuration word
    localparam int          POS_FUNCTION_SELECT     = 0;
    localparam int          POS_DIR      = 8;
    localparam int          POS_PULL_UP  = 9;
    localparam int          POS_PULL_DN  = 10;
    localparam int          POS_OPEN_DRAIN = 14;
    localparam int          POS_EVT      = 24;
    // event selections
    localparam logic [2:0]  EVT_FALL     = 3'h0;
    localparam logic [2:0]  EVT_RISE     = 3'h1;
    localparam logic [2:0]  EVT_BOTH     = 3'h2;
    localparam logic [2:0]  EVT_LOW      = 3'h3;
    localparam logic [2:0]  EVT_HIGH     = 3'h4;
    // reset values
    localparam logic [31:0] MASK_RST     = 32'h0000_0000;
    localparam logic [31:0] ODS_RST      = 32'h0000_0000;
    localparam logic [31:0] IMASK_RST    = 32'h0000_0000;
    localparam logic        CLK_EN_RST   = 1'b0;
    localparam logic        DIR_RST      = 1'b0;
    localparam logic [2:0]  EVT_RST      = 3'h0;
endpackage

// File: design/io_line_ctrl.sv
/*
 * seven groups of io lines with general purpose or peripheral
 * function per line, pulls, open drain and per-group interrupt.
 * assumes: apb3 master on sys_clk_i, pads resolved outside from
 * pad_o / pad_oe_o / pull enables, pad_i asynchronous.
 */
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps

// Functional notes
// - seven groups of 32 lines, 194 present, each with own registers
// - up to four peripherals per line; gpio-only lines ignore function
// - register writes work with the gated clock off
// - sampling and event detection run only with the gated clock on
// - the gated clock enable is off after reset
// - one interrupt per group, only while the gated clock is on
// - config read returns the lowest selected line
// - pull enables switch the pulls of every selected line
// - both pulls set means pull-up only
// - pull-up acts whatever the line direction or drive mode
// - function 0 is gpio, values 1 to 4 give the pad to a peripheral
// - unselected peripheral inputs get a fixed default
// - gpio direction set drives output data, cleared means input
// - set and clear registers change only the written one bits
// - direction and output data are kept while a peripheral owns it
// - direct output write changes only masked lines
// - open drain drives low only, and only in gpio mode
// - function, pull and open-drain reset values are parameters
// - pin status shows pad level, frozen while the clock is off
module io_line_ctrl
    import io_line_pkg::*;
#(
    parameter logic [NUM_LINES-1:0]           LINE_PRESENT =
        {32'h0000_0003, {6{32'hFFFF_FFFF}}},
    parameter logic [NUM_LINES-1:0]           MUX_CAPABLE  =
        {32'h0000_0003, {6{32'hFFFF_FFFF}}},
    parameter logic [NUM_LINES*FUNCTION_SELECT_W-1:0]    FUNCTION_SELECT_RESET   = '0,
    parameter logic [NUM_LINES-1:0]           PULL_UP_RESET  = '0,
    parameter logic [NUM_LINES-1:0]           PULL_DN_RESET  = '0,
    parameter logic [NUM_LINES-1:0]           OPEN_DRAIN_RESET = '0,
    parameter logic [NUM_LINES*NUM_FUNCS-1:0] PERIPH_DEFAULT = '0
) (
    input  wire logic                           sys_clk_i,
    input  wire logic                           reset_n_i,
    input  wire logic                           psel_i,
    input  wire logic                           penable_i,
    input  wire logic                           pwrite_i,
    input  wire logic [11:0]                    paddr_i,
    input  wire logic [31:0]                    pwdata_i,
    output logic      [31:0]                    prdata_o,
    output logic                                pready_o,
    output logic                                pslverr_o,
    input  wire logic [NUM_LINES-1:0]           pad_i,
    output logic      [NUM_LINES-1:0]           pad_o,
    output logic      [NUM_LINES-1:0]           pad_oe_o,
    output logic      [NUM_LINES-1:0]           pull_up_o,
    output logic      [NUM_LINES-1:0]           pull_down_o,
    input  wire logic [NUM_LINES*NUM_FUNCS-1:0] periph_out_i,
    input  wire logic [NUM_LINES*NUM_FUNCS-1:0] periph_oe_i,
    output logic      [NUM_LINES*NUM_FUNCS-1:0] periph_in_o,
    output logic      [NUM_GROUPS-1:0]          irq_o
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // index of the lowest set bit, 0 when none
    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h0;
        for (int i = GROUP_LINES - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // event test of one line from current and previous level
    function automatic logic evt_hit(input logic [2:0] sel,
                                     input logic cur, input logic prv);
        logic hit;
        case (sel)
            EVT_FALL: hit = prv & ~cur;
            EVT_RISE: hit = ~prv & cur;
            EVT_BOTH: hit = prv ^ cur;
            EVT_LOW:  hit = ~cur;
            EVT_HIGH: hit = cur;
            default:  hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************

    logic [FUNCTION_SELECT_W-1:0]    function_select_reg [NUM_LINES];
    logic [EVT_W-1:0]     evt_reg  [NUM_LINES];
    logic [NUM_LINES-1:0] dir_reg;
    logic [NUM_LINES-1:0] pull_up_reg;
    logic [NUM_LINES-1:0] pull_dn_reg;
    logic [NUM_LINES-1:0] open_drain_reg;
    logic [NUM_LINES-1:0] mask_reg;
    logic [NUM_LINES-1:0] ods_reg;
    logic [NUM_LINES-1:0] imask_reg;
    logic [NUM_LINES-1:0] istat_reg;
    logic [NUM_LINES-1:0] sync1_reg;
    logic [NUM_LINES-1:0] sync2_reg;
    logic [NUM_LINES-1:0] sync3_reg;
    logic [NUM_LINES-1:0] level_reg;
    logic [NUM_LINES-1:0] prev_reg;
    logic                 clk_en_reg;
    logic [31:0]          rdata_reg;
    logic [NUM_LINES-1:0] event_hit;

    // ****************************************************************
    // apb decode
    // ****************************************************************

    logic [2:0]  acc_grp;
    logic [5:0]  acc_ofs;
    logic        grp_ok;
    logic        reg_ok;
    logic        is_clk_en;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] sel_mask;
    logic [4:0]  first_line;
    logic [7:0]  first_idx;

    assign acc_grp    = paddr_i[8:6];
    assign acc_ofs    = paddr_i[5:0];
    assign is_clk_en  = (paddr_i == ADDR_CLK_EN);
    assign grp_ok     = (paddr_i[11:9] == 3'h0) && (acc_grp < 3'h7);
    assign reg_ok     = grp_ok && (acc_ofs inside {OFS_MASK, OFS_CFG,
                        OFS_PINS, OFS_SET, OFS_CLR, OFS_ODS, OFS_IEN,
                        OFS_IDIS, OFS_IMASK, OFS_ISTAT});
    // zero wait states; read data is caught in the setup cycle
    assign pready_o   = 1'b1;
    assign pslverr_o  = psel_i & penable_i & ~(reg_ok | is_clk_en);
    assign wr_en      = psel_i & penable_i & pwrite_i & reg_ok;
    assign rd_en      = psel_i & penable_i & ~pwrite_i & reg_ok;
    assign prdata_o   = rdata_reg;
    assign sel_mask   = mask_reg[32*acc_grp +: 32];
    assign first_line = lowest_set(sel_mask);
    assign first_idx  = {acc_grp, first_line};

    // read data mux, sampled one edge before the access phase
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            rdata_reg <= 32'h0000_0000;
            if (is_clk_en) begin
                rdata_reg <= {31'h0000_0000, clk_en_reg};
            end else if (grp_ok) begin
                case (acc_ofs)
                    OFS_MASK:  rdata_reg <= sel_mask;
                    OFS_CFG: begin
                        rdata_reg[POS_FUNCTION_SELECT +: FUNCTION_SELECT_W] <=
                            function_select_reg[first_idx];
                        rdata_reg[POS_DIR]        <= dir_reg[first_idx];
                        rdata_reg[POS_PULL_UP]    <= pull_up_reg[first_idx];
                        rdata_reg[POS_PULL_DN]    <= pull_dn_reg[first_idx];
                        rdata_reg[POS_OPEN_DRAIN] <= open_drain_reg[first_idx];
                        rdata_reg[POS_EVT +: EVT_W] <= evt_reg[first_idx];
                    end
                    OFS_PINS:  rdata_reg <= level_reg[32*acc_grp +: 32];
                    OFS_ODS:   rdata_reg <= ods_reg[32*acc_grp +: 32];
                    OFS_IMASK: rdata_reg <= imask_reg[32*acc_grp +: 32];
                    OFS_ISTAT: rdata_reg <= istat_reg[32*acc_grp +: 32];
                    default:   rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // register writes, all on the free-running bus clock
    // ****************************************************************

    // gated clock enable; software turns sampling on
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clk_en_reg <= CLK_EN_RST;
        end else if (psel_i && penable_i && pwrite_i && is_clk_en) begin
            clk_en_reg <= pwdata_i[0];
        end
    end

    // masks and output data; not gated so setup works before sampling
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_reg  <= {NUM_GROUPS{MASK_RST}};
            ods_reg   <= {NUM_GROUPS{ODS_RST}};
            imask_reg <= {NUM_GROUPS{IMASK_RST}};
        end else if (wr_en) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (acc_grp == 3'(g)) begin
                    case (acc_ofs)
                        OFS_MASK: mask_reg[32*g +: 32] <= pwdata_i;
                        OFS_SET:  ods_reg[32*g +: 32] <=
                            ods_reg[32*g +: 32] | pwdata_i;
                        OFS_CLR:  ods_reg[32*g +: 32] <=
                            ods_reg[32*g +: 32] & ~pwdata_i;
                        OFS_ODS:  ods_reg[32*g +: 32] <=
                            (ods_reg[32*g +: 32] & ~mask_reg[32*g +: 32])
                            | (pwdata_i & mask_reg[32*g +: 32]);
                        OFS_IEN:  imask_reg[32*g +: 32] <=
                            imask_reg[32*g +: 32] | pwdata_i;
                        OFS_IDIS: imask_reg[32*g +: 32] <=
                            imask_reg[32*g +: 32] & ~pwdata_i;
                        default: ;
                    endcase
                end
            end
        end
    end

    // config word applied to every selected line of the group at once
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int n = 0; n < NUM_LINES; n++) begin
                function_select_reg[n] <= FUNCTION_SELECT_RESET[n*FUNCTION_SELECT_W +: FUNCTION_SELECT_W];
                evt_reg[n]  <= EVT_RST;
            end
            dir_reg  <= {NUM_LINES{DIR_RST}};
            pull_up_reg    <= PULL_UP_RESET;
            pull_dn_reg    <= PULL_DN_RESET;
            open_drain_reg <= OPEN_DRAIN_RESET;
        end else if (wr_en && acc_ofs == OFS_CFG) begin
            for (int n = 0; n < NUM_LINES; n++) begin
                if (acc_grp == 3'(n / 32) && mask_reg[n] &&
                    LINE_PRESENT[n]) begin
                    // a gpio-only line keeps function 0
                    function_select_reg[n] <= MUX_CAPABLE[n] ?
                        pwdata_i[POS_FUNCTION_SELECT +: FUNCTION_SELECT_W] : 3'h0;
                    dir_reg[n]        <= pwdata_i[POS_DIR];
                    pull_up_reg[n]    <= pwdata_i[POS_PULL_UP];
                    pull_dn_reg[n]    <= pwdata_i[POS_PULL_DN];
                    open_drain_reg[n] <= pwdata_i[POS_OPEN_DRAIN];
                    evt_reg[n]        <= pwdata_i[POS_EVT +: EVT_W];
                end
            end
        end
    end

    // ****************************************************************
    // pad sampling on the gated clock
    // ****************************************************************

    // three stages; a change is taken once stages two and three agree.
    // with the clock gated off everything freezes, so the status keeps
    // the levels seen when it stopped
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            level_reg <= '0;
            prev_reg  <= '0;
        end else if (clk_en_reg) begin
            sync1_reg <= pad_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            level_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg) |
                         ((sync2_reg ^ sync3_reg) & level_reg);
            prev_reg  <= level_reg;
        end
    end

    // per-line event detection, dead while the clock is off
    always_comb begin
        for (int n = 0; n < NUM_LINES; n++) begin
            event_hit[n] = clk_en_reg && LINE_PRESENT[n] &&
                           evt_hit(evt_reg[n], level_reg[n], prev_reg[n]);
        end
    end

    // sticky status, cleared by reading the group; a new event wins
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            istat_reg <= '0;
        end else begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (rd_en && acc_ofs == OFS_ISTAT && acc_grp == 3'(g)) begin
                    istat_reg[32*g +: 32] <= event_hit[32*g +: 32];
                end else begin
                    istat_reg[32*g +: 32] <= istat_reg[32*g +: 32] |
                                             event_hit[32*g +: 32];
                end
            end
        end
    end

    // ****************************************************************
    // pad and peripheral outputs, registered
    // ****************************************************************

    // a function above four has no peripheral and falls back to gpio
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_o       <= '0;
            pad_oe_o    <= '0;
            pull_up_o   <= '0;
            pull_down_o <= '0;
            periph_in_o <= PERIPH_DEFAULT;
            irq_o       <= '0;
        end else begin
            for (int n = 0; n < NUM_LINES; n++) begin
                if (!LINE_PRESENT[n]) begin
                    pad_o[n]    <= 1'b0;
                    pad_oe_o[n] <= 1'b0;
                end else if (function_select_reg[n] != 3'h0 &&
                             function_select_reg[n] <= 3'(NUM_FUNCS)) begin
                    // peripheral owns data and drive enable
                    pad_o[n]    <= periph_out_i[n*4 + 32'(function_select_reg[n]) - 1];
                    pad_oe_o[n] <= periph_oe_i[n*4 + 32'(function_select_reg[n]) - 1];
                end else if (open_drain_reg[n]) begin
                    pad_o[n]    <= 1'b0;
                    pad_oe_o[n] <= dir_reg[n] & ~ods_reg[n];
                end else begin
                    pad_o[n]    <= ods_reg[n];
                    pad_oe_o[n] <= dir_reg[n];
                end
                // pull-up wins over pull-down in every mode
                pull_up_o[n]   <= LINE_PRESENT[n] & pull_up_reg[n];
                pull_down_o[n] <= LINE_PRESENT[n] &
                                  pull_dn_reg[n] & ~pull_up_reg[n];
                for (int f = 0; f < NUM_FUNCS; f++) begin
                    periph_in_o[n*4 + f] <=
                        (function_select_reg[n] == 3'(f + 1) && LINE_PRESENT[n]) ?
                        level_reg[n] : PERIPH_DEFAULT[n*4 + f];
                end
            end
            for (int g = 0; g < NUM_GROUPS; g++) begin
                irq_o[g] <= clk_en_reg &&
                    |(istat_reg[32*g +: 32] & imask_reg[32*g +: 32]);
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************

    a_pull_up_wins: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (pull_up_o & pull_down_o) == '0)
        else $error("pull-up and pull-down both enabled");

    a_irq_needs_clk: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (irq_o != '0) |-> $past(clk_en_reg))
        else $error("interrupt while gated clock off");

    a_level_frozen: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !clk_en_reg |=> $stable(level_reg))
        else $error("pin status moved with clock off");

    a_set_output: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (wr_en && acc_ofs == OFS_SET && acc_grp == 3'h0) |=>
        ods_reg[31:0] == ($past(ods_reg[31:0]) | $past(pwdata_i)))
        else $error("set output wrong");

    a_clear_output: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (wr_en && acc_ofs == OFS_CLR && acc_grp == 3'h0) |=>
        ods_reg[31:0] == ($past(ods_reg[31:0]) & ~$past(pwdata_i)))
        else $error("clear output wrong");

    a_direct_masked: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (wr_en && acc_ofs == OFS_ODS && acc_grp == 3'h0) |=>
        ((ods_reg[31:0] ^ $past(ods_reg[31:0])) & ~mask_reg[31:0]) == '0)
        else $error("direct write hit unmasked line");

    a_mask_no_clk: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (wr_en && acc_ofs == OFS_MASK && acc_grp == 3'h1 && !clk_en_reg)
        |=> mask_reg[63:32] == $past(pwdata_i))
        else $error("mask write lost with clock off");

    a_pull_follows: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (wr_en && acc_ofs == OFS_CFG && acc_grp == 3'h0 && mask_reg[0])
        |-> ##2 pull_up_o[0] == $past(pwdata_i[POS_PULL_UP], 2))
        else $error("pull-up not following config");

endmodule

// File: verification/io_pad_model.sv
/* pads and peripherals at the far side of the io line controller.
   assumes the bench picks which pads are driven from outside. */
`timescale 1ns/10ps
module io_pad_model
    import io_line_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic [NUM_LINES-1:0]       drv_i,
    input  wire logic [NUM_LINES-1:0]       oe_i,
    input  wire logic [NUM_LINES-1:0]       pu_i,
    input  wire logic [NUM_LINES-1:0]       pd_i,
    input  wire logic [NUM_LINES-1:0]       ext_en_i,
    input  wire logic [NUM_LINES-1:0]       ext_val_i,
    input  wire logic                       p_lvl_i,
    output logic      [NUM_LINES-1:0]       lvl_o,
    output logic      [NUM_LINES*4-1:0]     p_out_o,
    output logic      [NUM_LINES*4-1:0]     p_oe_o
);
    // ****
    // pad resolution
    // ****
    logic flip_reg = 1'b0;
    // an unpulled floating pad wanders, so no stale level is trusted
    always_ff @(posedge clk_i) begin
        flip_reg <= ~flip_reg;
    end
    // own driver first, then the outside source, then the pulls
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
        | (~oe_i & ~ext_en_i & (pu_i | (~pd_i & {NUM_LINES{flip_reg}})));
    // every peripheral slot drives one common level
    assign p_out_o = {(NUM_LINES*4){p_lvl_i}};
    assign p_oe_o  = {(NUM_LINES*4){1'b1}};
endmodule

// File: verification/multiplexed_io_line_controller_bench.sv
/* directed apb scenarios for the io line controller.
   assumes io_pad_model resolves the pads. */
`timescale 1ns/10ps
module multiplexed_io_line_controller_bench
    import io_line_pkg::*;
;
    // ****
    // stimulus and checks
    // ****
    localparam logic [31:0] DIR = 32'h1 << POS_DIR;
    localparam logic [31:0] PU  = 32'h1 << POS_PULL_UP;
    localparam logic [31:0] PD  = 32'h1 << POS_PULL_DN;
    localparam logic [31:0] OD  = 32'h1 << POS_OPEN_DRAIN;
    logic                   clk, rst_n, psel, pen, pwr, slv, pready;
    logic                   pslverr, p_lvl;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rd;
    logic [NUM_LINES-1:0]   lvl, pad, oe, pu, pd, ext_en, ext_val;
    logic [NUM_LINES*4-1:0] p_out, p_oe, p_in;
    logic [NUM_GROUPS-1:0]  irq;
    int                     n_fail, num_checks;
    // line 5 of group 0 is wired as general purpose only
    io_line_ctrl #(
        .MUX_CAPABLE({32'h0000_0003, {5{32'hFFFF_FFFF}}, 32'hFFFF_FFDF})
    ) io_line_ctrl_inst (.sys_clk_i(clk), .reset_n_i(rst_n),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .pad_i(lvl), .pad_o(pad), .pad_oe_o(oe),
        .pull_up_o(pu), .pull_down_o(pd), .periph_out_i(p_out),
        .periph_oe_i(p_oe), .periph_in_o(p_in), .irq_o(irq));
    io_pad_model io_pad_model_inst (.clk_i(clk), .drv_i(pad), .oe_i(oe),
        .pu_i(pu), .pd_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .p_lvl_i(p_lvl), .lvl_o(lvl), .p_out_o(p_out), .p_oe_o(p_oe));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one apb transfer; waits for pready, only the watchdog bounds it
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [11:0] a, e);
        apb(1'b0, a, 32'h0);
        chk(n, rd, {20'h0, e});
    endtask
    task automatic nx(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [11:0] ad(input int g, input logic [5:0] o);
        return 12'(g * 64) + {6'h0, o};
    endfunction
    // reset state, then mask-first configuration with the clock off
    task automatic t_cfg;
        chk("idle", 32'({|oe, |pu, |pd, |irq}), 32'h0);
        rdc("clk_en", ADDR_CLK_EN, 12'h0);
        wr(ad(1, OFS_MASK), 32'h9);
        wr(ad(1, OFS_CFG), DIR | PU | PD);
        wr(ad(1, OFS_MASK), 32'h8);
        wr(ad(1, OFS_CFG), DIR);
        wr(ad(1, OFS_SET), 32'h1);
        nx(1);
        chk("pulls", 32'({pu[32], pd[32], pu[35]}), 32'h4);
        chk("drv", 32'({oe[32], pad[32], oe[35], pad[35]}), 32'hE);
        wr(ad(1, OFS_MASK), 32'h9);
        apb(1'b0, ad(1, OFS_CFG), 32'h0);
        chk("cfg", rd, DIR | PU | PD);
        wr(ad(2, OFS_SET), 32'hF);
        wr(ad(2, OFS_CLR), 32'h5);
        rdc("ods_sc", ad(2, OFS_ODS), 12'hA);
        wr(ad(2, OFS_MASK), 32'h3);
        wr(ad(2, OFS_ODS), 32'hFFFF_FFF1);
        rdc("ods_msk", ad(2, OFS_ODS), 12'h9);
    endtask
    // peripheral ownership, general purpose only line, open drain
    task automatic t_function_select;
        wr(ad(0, OFS_MASK), 32'h21);
        wr(ad(0, OFS_CFG), DIR | PU | 32'h1);
        wr(ad(0, OFS_SET), 32'h21);
        nx(1);
        chk("per0", 32'({oe[0], pad[0]}), 32'h2);
        chk("gpio5", 32'({pad[5], p_in[20]}), 32'h2);
        @(posedge clk);
        p_lvl <= 1'b1;
        nx(2);
        chk("per1", 32'(pad[0]), 32'h1);
        wr(ad(0, OFS_MASK), 32'h1);
        p_lvl <= 1'b0;
        wr(ad(0, OFS_CFG), DIR);
        nx(1);
        chk("kept", 32'(pad[0]), 32'h1);
        wr(ad(3, OFS_MASK), 32'h1);
        wr(ad(3, OFS_CFG), DIR | OD | PU);
        wr(ad(3, OFS_SET), 32'h1);
        nx(1);
        chk("od_hi", 32'({oe[96], pu[96]}), 32'h1);
        wr(ad(3, OFS_CLR), 32'h1);
        nx(1);
        chk("od_lo", 32'({oe[96], pad[96]}), 32'h2);
        wr(ad(6, OFS_MASK), 32'h6);
        wr(ad(6, OFS_CFG), DIR);
        nx(1);
        chk("absent", 32'({oe[194], oe[193]}), 32'h1);
        apb(1'b0, 12'h3FC, 32'h0);
        chk("unmapped", 32'(slv), 32'h1);
    endtask
    // pin sampling and the group interrupt against the gated clock
    task automatic t_pins;
        @(posedge clk);
        ext_val[128] <= 1'b1;
        nx(6);
        rdc("frozen", ad(4, OFS_PINS), 12'h0);
        wr(ADDR_CLK_EN, 32'h1);
        nx(6);
        rdc("pin_on", ad(4, OFS_PINS), 12'h1);
        wr(ad(4, OFS_MASK), 32'h1);
        wr(ad(4, OFS_CFG), {5'h0, EVT_RISE, 24'h0});
        wr(ad(4, OFS_IEN), 32'h1);
        ext_val[128] <= 1'b0;
        nx(8);
        chk("no_fall", 32'(irq), 32'h0);
        @(posedge clk);
        ext_val[128] <= 1'b1;
        nx(8);
        chk("irq_on", 32'(irq), 32'h10);
        rdc("istat", ad(4, OFS_ISTAT), 12'h1);
        nx(2);
        chk("irq_off", 32'(irq), 32'h0);
        // leave a level event pending so the gating below is visible
        wr(ad(4, OFS_CFG), {5'h0, EVT_HIGH, 24'h0});
        nx(8);
        chk("irq_lvl", 32'(irq), 32'h10);
        wr(ADDR_CLK_EN, 32'h0);
        ext_val[128] <= 1'b0;
        nx(8);
        rdc("held", ad(4, OFS_PINS), 12'h1);
        ext_val[128] <= 1'b1;
        nx(8);
        chk("gated", 32'(irq), 32'h0);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        {psel, pen, pwr, p_lvl, rst_n} = 5'h0;
        {paddr, pwdata} = 44'h0;
        ext_en = '1;
        ext_val = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        nx(1);
        t_cfg;
        t_function_select;
        t_pins;
        tally_and_finish;
    end
    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        #200000;
        n_fail++;
        tally_and_finish;
    end
endmodule
